// [hw/sbit_counter.sv]
// counting stage: advances a count on each tick from the front end
// assumes ticks are single-cycle pulses in the i_clk domain
`timescale 1ns/1ps
module sbit_counter
  import sbit_pkg::*;
#(
  parameter int unsigned WIDTH = COUNT_W
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_arst_n,
  input  wire logic             i_ce,
  // tick source
  sbit_if.count                 link,
  // count out
  output logic [WIDTH-1:0]      o_count
);

  initial begin
    if (WIDTH < 2 || WIDTH > 32) $error("sbit_counter: WIDTH out of range");
  end

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } sbit_cnt_state_type;

  sbit_cnt_state_type state_reg;
  sbit_cnt_state_type state_next;

  always_comb begin
    state_next = state_reg;
    // free running: wraps at all ones
    if (link.tick) begin
      state_next.count = state_reg.count + WIDTH'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= '0;
    end else if (i_ce) begin
      state_reg <= state_next;
    end
  end

  assign o_count = state_reg.count;

endmodule

// [hw/sbit_if.sv]
// interface carrying the tick and mode from the timer front end to its counter
// assumes both ends share i_clk
`timescale 1ns/1ps
interface sbit_if;
  import sbit_pkg::*;
  logic          tick;
  sbit_mode_type mode;
  modport front (output tick, output mode);
  modport count (input tick, input mode);
endinterface

// [hw/sbit_pkg.sv]
// package for the sixteen-bit interval timer: control word layout, modes, widths
// assumes nothing beyond a SystemVerilog compiler
package sbit_pkg;

  // ****************************************
  // control word layout
  // ****************************************
  localparam int unsigned CTRL_W            = 16;
  localparam int unsigned CLK_SRC_BIT       = 1;
  localparam int unsigned SYNC_EN_BIT       = 2;
  localparam int unsigned GATE_EN_BIT       = 6;
  localparam logic [15:0] CTRL_RESET        = 16'h0000;

  // ****************************************
  // counter and prescaler
  // ****************************************
  localparam int unsigned COUNT_W           = 16;
  localparam logic [15:0] COUNT_RESET       = 16'h0000;
  localparam int unsigned PRESCALE_W        = 8;
  localparam logic [7:0]  PRESCALE_RESET    = 8'h00;

  // ****************************************
  // modes
  // ****************************************
  typedef enum logic [1:0] {
    SBIT_TIMER       = 2'b00,
    SBIT_GATED_TIMER = 2'b01,
    SBIT_SYNC_COUNT  = 2'b10,
    SBIT_ASYNC_COUNT = 2'b11
  } sbit_mode_type;

  function automatic sbit_mode_type sbit_decode_mode(input logic [15:0] ctrl);
    sbit_mode_type m;
    m = SBIT_TIMER;
    if (ctrl[CLK_SRC_BIT]) begin
      m = ctrl[SYNC_EN_BIT] ? SBIT_SYNC_COUNT : SBIT_ASYNC_COUNT;
    end else if (ctrl[GATE_EN_BIT]) begin
      m = SBIT_GATED_TIMER;
    end
    return m;
  endfunction

endpackage

// [hw/sbit_timer.sv]
// sixteen-bit interval timer: mode decode, prescaler, optional sync, counter
// assumes inputs are synchronous to i_clk; the control word comes from a parent
//
// Function
// - free-running sixteen-bit timer or event counter
// - asynchronous counter mode counts external input
// - sync after prescaler, only when selected
// - timer modes count instruction-cycle clock
// - counter modes count external input pin
// - clock source select in control bit 1
// - external sync enable in control bit 2
// - gate enable in control bit 6
// - mode decode from source, sync, gate
`timescale 1ns/1ps
module sbit_timer
  import sbit_pkg::*;
#(
  parameter int unsigned WIDTH = COUNT_W,
  parameter int unsigned PS_W  = PRESCALE_W
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_arst_n,
  input  wire logic             i_ce,
  // control word and prescale ratio
  input  wire logic [15:0]      i_primary_timer_control_word,
  input  wire logic [PS_W-1:0]  i_prescale_div,
  // clocks and pins
  input  wire logic             i_instruction_cycle_clock,
  input  wire logic             i_external_count_input,
  input  wire logic             i_gate,
  // status
  output logic [WIDTH-1:0]      o_count,
  output logic [1:0]            o_mode
);

  initial begin
    if (PS_W < 1 || PS_W > 16) $error("sbit_timer: PS_W out of range");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic            ext_prev;
    logic [PS_W-1:0] ps_cnt;
    logic            ps_out;
    logic            sync1;
    logic            sync2;
    logic            sync_prev;
    logic            tick;
    logic [1:0]      mode;
  } sbit_state_type;

  sbit_state_type state_reg;
  sbit_state_type state_next;

  sbit_if        link ();
  sbit_mode_type mode;
  logic          src_edge;
  logic          ps_pulse;
  logic          ext_edge;

  // only the three documented bits matter; the rest are ignored
  assign mode = sbit_decode_mode(i_primary_timer_control_word);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    state_next          = state_reg;
    state_next.mode     = mode;
    state_next.ext_prev = i_external_count_input;
    src_edge            = 1'b0;
    ps_pulse            = 1'b0;
    ext_edge            = i_external_count_input & ~state_reg.ext_prev;

    unique case (mode)
      SBIT_TIMER: begin
        src_edge = i_instruction_cycle_clock;
      end
      SBIT_GATED_TIMER: begin
        src_edge = i_instruction_cycle_clock & i_gate;
      end
      SBIT_SYNC_COUNT, SBIT_ASYNC_COUNT: begin
        src_edge = ext_edge;
      end
    endcase

    // prescaler divides source edges (cycle clock or external edges) by i_prescale_div + 1
    if (src_edge) begin
      if (state_reg.ps_cnt == i_prescale_div) begin
        state_next.ps_cnt = '0;
        ps_pulse          = 1'b1;
      end else begin
        state_next.ps_cnt = state_reg.ps_cnt + PS_W'(1);
      end
    end
    // prescaled output held as a level so the sync stage sees it
    if (ps_pulse) begin
      state_next.ps_out = ~state_reg.ps_out;
    end

    // sync stage sits after the prescaler
    state_next.sync1     = state_reg.ps_out;
    state_next.sync2     = state_reg.sync1;
    state_next.sync_prev = state_reg.sync2;

    // async path bypasses the sync stage; no stall on the device clock
    if (mode == SBIT_SYNC_COUNT) begin
      state_next.tick = state_reg.sync2 ^ state_reg.sync_prev;
    end else begin
      state_next.tick = ps_pulse;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= '0;
    end else if (i_ce) begin
      state_reg <= state_next;
    end
  end

  assign link.tick = state_reg.tick;
  assign link.mode = sbit_mode_type'(state_reg.mode);
  assign o_mode    = state_reg.mode;

  // ****************************************
  // counter
  // ****************************************
  sbit_counter #(
    .WIDTH    (WIDTH)
  ) u_counter (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_ce     (i_ce),
    .link     (link.count),
    .o_count  (o_count)
  );

endmodule

// [sim/sbit_ext_src.sv]
// partner: count pin source, one-cycle pulses
// assumes the pin is pulled low while off
`timescale 1ns/1ps
module sbit_ext_src (
  input  wire logic       i_clk,
  input  wire logic       i_en,
  input  wire logic [2:0] i_gap,
  output logic            o_ext = 1'b0
);
  logic [3:0] cnt_reg = 4'h0;
  always @(posedge i_clk) begin
    o_ext <= i_en && cnt_reg == 4'h0;
    if (cnt_reg != 4'h0) cnt_reg <= cnt_reg - 4'h1;
    else if (i_en) cnt_reg <= i_gap + 4'h1;
  end
endmodule

// [sim/sbit_timer_sva.sv]
// checker bound into the timer top
// assumes one clock, async low reset
`timescale 1ns/1ps
module sbit_timer_sva (
  input wire logic        i_clk,
  input wire logic        i_arst_n,
  input wire logic        i_ce,
  input wire logic [15:0] i_primary_timer_control_word,
  input wire logic        i_instruction_cycle_clock,
  input wire logic        i_external_count_input,
  input wire logic        i_gate,
  input wire logic [15:0] o_count,
  input wire logic [1:0]  o_mode
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  logic [15:0] w;
  logic [2:0]  rh;
  logic        t, x;
  assign w = i_primary_timer_control_word;
  assign t = i_instruction_cycle_clock;
  assign x = i_external_count_input;
  // edges since release, so $past never reaches into reset
  always_ff @(posedge i_clk or negedge i_arst_n)
    if (!i_arst_n) rh <= 3'h0;
    else rh <= {rh[1:0], 1'b1};
  AST_STEP: assert property (rh[0] && $changed(o_count) |->
    o_count == $past(o_count) + 16'h0001) else $error("count jumped");
  AST_FRZ: assert property (rh[0] && !$past(i_ce) |->
    $stable(o_count) && $stable(o_mode)) else $error("moved while frozen");
  AST_SRC: assert property (rh[0] && $past(i_ce) |-> o_mode[1] == $past(w[1]))
    else $error("source decode");
  AST_SYN: assert property (rh[0] && $past(i_ce && w[1]) |-> o_mode[0] != $past(w[2]))
    else $error("sync decode");
  AST_GAT: assert property (rh[0] && $past(i_ce && !w[1]) |-> o_mode[0] == $past(w[6]))
    else $error("gate decode");
  // a tick frozen by a low enable lands late, so only unfrozen spans are judged
  AST_TMR: assert property (rh[2] && $past(i_ce) && $past(i_ce, 2) &&
    $past(o_mode) == 2'h0 && $changed(o_count) |->
    $past(t, 2)) else $error("timer count without cycle");
  AST_GTD: assert property (rh[2] && $past(i_ce) && $past(i_ce, 2) &&
    $past(o_mode) == 2'h1 && $changed(o_count) |->
    $past(t && i_gate, 2)) else $error("gated count while closed");
  AST_ASY: assert property (rh[2] && $past(i_ce) && $past(i_ce, 2) &&
    $past(o_mode) == 2'h3 && $changed(o_count) |->
    $past(x, 2) && !$past(x, 3)) else $error("async count without edge");
endmodule
bind sbit_timer sbit_timer_sva i_sbit_timer_sva (.*);

// [sim/sbit_timer_tb_top.sv]
// bench: random pin traffic against a counting model
// assumes sbit_ext_src drives the count pin
`timescale 1ns/1ps
module sbit_timer_tb_top;
  logic        i_clk = 0, i_arst_n = 0, i_ce = 1, icc = 0, gate = 0, en = 0, ext, prv = 0;
  logic [15:0] ctrl = 16'h0000, o_count, ex = 16'h0000;
  logic [7:0]  div = 8'h00;
  logic [2:0]  gap = 3'h0;
  logic [1:0]  o_mode;
  int          n_errors = 0, num_checks = 0, seed = 32'h4ddd, ps = 0, m = 0;
  always #5 i_clk = ~i_clk;
  sbit_ext_src i_sbit_ext_src (.i_clk, .i_en(en), .i_gap(gap), .o_ext(ext));
  sbit_timer i_sbit_timer (.i_clk, .i_arst_n, .i_ce, .i_primary_timer_control_word(ctrl),
    .i_prescale_div(div), .i_instruction_cycle_clock(icc), .i_external_count_input(ext),
    .i_gate(gate), .o_count, .o_mode);
  always @(posedge i_clk) if (i_arst_n && i_ce) begin
    m = ctrl[1] ? 3 - ctrl[2] : ctrl[6];
    if (m == 0 ? icc : m == 1 ? icc & gate : ext & !prv) begin
      ex += ps == div;
      // eight-bit prescaler wraps when a smaller ratio lands below its count
      ps = ps == div ? 0 : (ps + 1) % 256;
    end
    prv = ext;
  end
  task automatic cmp(input logic [15:0] got, want);
    num_checks++;
    if (got !== want) n_errors++;
    if (got !== want) $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
  endtask
  task automatic cmp_mode(input logic [1:0] got, want);
    num_checks++;
    if (got !== want) n_errors++;
    if (got !== want) $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
  endtask
  task automatic print_verdict;
    if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // f[0] random enable, f[1] cycle clock every edge
  task automatic run(input logic [15:0] c, input int n, input bit [1:0] f);
    ctrl <= c;
    div <= {6'h00, c[9:8]};
    repeat (4) @(posedge i_clk);
    en <= c[1];
    repeat (n) @(posedge i_clk) begin
      icc <= f[1] | $random(seed);
      {gate, gap} <= $random(seed);
      if (f[0]) i_ce <= $random(seed);
    end
    @(posedge i_clk) {icc, en, i_ce} <= 3'b001;
    repeat (10) @(posedge i_clk);
    cmp(o_count, ex);
    cmp_mode(o_mode, c[1] ? {1'b1, !c[2]} : {1'b0, c[6]});
  endtask
  initial begin
    repeat (20) @(posedge i_clk);
    i_arst_n <= 1;
    for (int k = 0; k < 8; k++)
      run(16'($random(seed) & 16'hFFB9 | k[2] << 1 | k[1] << 2 | k[0] << 6), 100, 0);
    run(16'h0000, 200, 2'b11);
    run(16'h0000, 65600, 2'b10);
    print_verdict;
  end
  initial begin
    #1000000;
    n_errors++;
    print_verdict;
  end
endmodule
